/* File: hdl/mcts_cycle_sync.sv */
// Shared cycle trigger: master start generator, ready line and local cycle timers
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`default_nettype none
//
// Contract
// - Master's cycle manager makes the cycle trigger and broadcasts it on the link.
// - Every device, master too, triggers its cycle from the shared link stream.
// - All cycles begin together; each device keeps its own timing settings.
// - The ready mechanism exists only in area-scan mode, never in line-scan.
// - Ready line is a wired-AND; any one slave can hold it false.
// - A slave holds ready false while any local start condition is unmet.
// - Master withholds the trigger while the ready line reads false.
// - Once ready is confirmed high, master drives a falling edge on cycle-start.
// - The cycle-start falling edge starts the cycle timers of every device.
// - After cycle start each device forces ready low until locally ready again.
// - Timers give camera trigger and strobe, each with own delay and width.
// - Master keeps cycle-start edges at least 400 ns apart.
module mcts_cycle_sync
   import mcts_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic cycle_trigger_in,
   input wire logic local_ready,
   input wire logic ready_line_in,
   output mcts_pin_drv_t ready_line,
   input wire logic start_line_in,
   output mcts_pin_drv_t start_line,
   output logic camera_trigger,
   output logic strobe,
   output logic cycle_active
);
   // Settings
   logic [6:0] ctrl_r;
   mcts_pulse_cfg_t cam_cfg_r;
   mcts_pulse_cfg_t stb_cfg_r;
   logic role_master;
   logic area_scan;
   logic enabled;
   logic src_is_cycle;
   logic master_on;
   logic master_arm;

   // Pin synchronisers
   logic ready_s1_r;
   logic ready_s2_r;
   logic start_s1_r;
   logic start_s2_r;
   logic start_s3_r;
   logic start_fall;

   // Master sequencing
   mcts_master_state_t mstate_r;
   logic pend_r;
   logic [CNT_W-1:0] ready_hi_r;
   logic ready_settled;
   logic [CNT_W-1:0] low_cnt_r;
   logic [CNT_W-1:0] period_cnt_r;
   logic [CNT_W-1:0] guard_cnt_r;
   logic period_ok;
   logic start_go;
   logic hold_low;

   // Local cycle state
   logic [1:0] timer_start;
   logic [1:0] timer_pulse;
   logic [1:0] timer_busy;
   mcts_pulse_cfg_t timer_cfg [2];
   logic local_go;
   logic timers_idle;
   logic [31:0] status_word;
   logic [31:0] cycle_count_r;

   assign role_master = ctrl_r[CTRL_MASTER_BIT];
   assign area_scan = ctrl_r[CTRL_AREA_BIT];
   assign enabled = ctrl_r[CTRL_EN_BIT];
   assign src_is_cycle = (ctrl_r[CTRL_SRC_LSB +: 2] == SRC_CYCLE_TRIGGER);

   // Master duties need the master role and the enable together
   assign master_on = role_master && enabled;
   assign master_arm = master_on && src_is_cycle;

   // Control register write
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r <= CTRL_RST;
      end else if (reg_wr && (reg_addr == ADDR_CTRL)) begin
         ctrl_r <= reg_wdata[6:0];
      end
   end

   // Pulse timing writes; each device keeps its own settings
   always_ff @(posedge clk) begin
      if (rst) begin
         cam_cfg_r <= '{delay: DELAY_RST, width: WIDTH_RST};
         stb_cfg_r <= '{delay: DELAY_RST, width: WIDTH_RST};
      end else if (reg_wr) begin
         unique case (reg_addr)
            ADDR_CAM_DELAY: cam_cfg_r.delay <= reg_wdata[TW-1:0];
            ADDR_CAM_WIDTH: cam_cfg_r.width <= reg_wdata[TW-1:0];
            ADDR_STB_DELAY: stb_cfg_r.delay <= reg_wdata[TW-1:0];
            ADDR_STB_WIDTH: stb_cfg_r.width <= reg_wdata[TW-1:0];
            default: begin
            end
         endcase
      end
   end

   // Status word as software sees it
   always_comb begin
      status_word = '0;
      status_word[STAT_ACTIVE_BIT] = cycle_active;
      status_word[STAT_READY_BIT] = ready_s2_r;
      status_word[STAT_PEND_BIT] = pend_r;
      status_word[STAT_LOCAL_BIT] = local_go;
   end

   // Register reads, data in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ADDR_CTRL: reg_rdata <= {25'h0000000, ctrl_r};
            ADDR_CAM_DELAY: reg_rdata <= {16'h0000, cam_cfg_r.delay};
            ADDR_CAM_WIDTH: reg_rdata <= {16'h0000, cam_cfg_r.width};
            ADDR_STB_DELAY: reg_rdata <= {16'h0000, stb_cfg_r.delay};
            ADDR_STB_WIDTH: reg_rdata <= {16'h0000, stb_cfg_r.width};
            ADDR_STATUS: reg_rdata <= status_word;
            ADDR_CYCLE_COUNT: reg_rdata <= cycle_count_r;
            default: reg_rdata <= RDATA_UNMAPPED;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // Two-stage synchroniser for the shared ready line
   always_ff @(posedge clk) begin
      if (rst) begin
         ready_s1_r <= 1'b0;
         ready_s2_r <= 1'b0;
      end else begin
         ready_s1_r <= ready_line_in;
         ready_s2_r <= ready_s1_r;
      end
   end

   // Two-stage synchroniser plus edge stage for the shared start line
   always_ff @(posedge clk) begin
      if (rst) begin
         start_s1_r <= 1'b1;
         start_s2_r <= 1'b1;
         start_s3_r <= 1'b1;
      end else begin
         start_s1_r <= start_line_in;
         start_s2_r <= start_s1_r;
         start_s3_r <= start_s2_r;
      end
   end

   // Falling edge of the shared cycle-start stream, same path for master and slaves
   assign start_fall = enabled && start_s3_r && !start_s2_r;

   // Ready counts as settled after enough consecutive high samples
   always_ff @(posedge clk) begin
      if (rst) begin
         ready_hi_r <= '0;
      end else if (!ready_s2_r) begin
         ready_hi_r <= '0;
      end else if (ready_hi_r != CNT_W'(READY_CONFIRM_CYC)) begin
         ready_hi_r <= ready_hi_r + 4'h1;
      end
   end
   // Line-scan mode has no ready mechanism, so the line is not consulted
   assign ready_settled = !area_scan || (ready_hi_r == CNT_W'(READY_CONFIRM_CYC));

   // Pending cycle trigger from the cycle manager; a new request wins over the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         pend_r <= 1'b0;
      end else if (!master_arm) begin
         pend_r <= 1'b0;
      end else if (cycle_trigger_in) begin
         pend_r <= 1'b1;
      end else if (mstate_r == MS_WAIT_READY && ready_settled && period_ok) begin
         pend_r <= 1'b0;
      end
   end

   // Cycles since the last own falling edge, saturating
   always_ff @(posedge clk) begin
      if (rst) begin
         period_cnt_r <= CNT_W'(MIN_START_CYC);
      end else if (start_go) begin
         period_cnt_r <= '0;
      end else if (period_cnt_r != CNT_W'(MIN_START_CYC)) begin
         period_cnt_r <= period_cnt_r + 4'h1;
      end
   end
   // The edge goes out one cycle after the decision, so spacing is exactly honoured
   assign period_ok = (period_cnt_r >= CNT_W'(MIN_START_CYC - 1));

   // Decision to pull the start line low from the next cycle on
   assign start_go = (mstate_r == MS_WAIT_READY) && pend_r && ready_settled && period_ok;

   // Master start sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         mstate_r <= MS_IDLE;
         low_cnt_r <= '0;
         guard_cnt_r <= '0;
      end else if (!master_on) begin
         mstate_r <= MS_IDLE;
         low_cnt_r <= '0;
         guard_cnt_r <= '0;
      end else begin
         unique case (mstate_r)
            MS_IDLE: begin
               if (pend_r || cycle_trigger_in) begin
                  mstate_r <= MS_WAIT_READY;
               end
            end
            MS_WAIT_READY: begin
               // Hold back while the shared ready line is low
               if (pend_r && ready_settled && period_ok) begin
                  mstate_r <= MS_DRIVE_LOW;
                  low_cnt_r <= CNT_W'(START_LOW_CYC - 1);
               end else if (!pend_r) begin
                  mstate_r <= MS_IDLE;
               end
            end
            MS_DRIVE_LOW: begin
               if (low_cnt_r == '0) begin
                  mstate_r <= MS_GUARD;
                  guard_cnt_r <= CNT_W'(SYNC_GUARD_CYC);
               end else begin
                  low_cnt_r <= low_cnt_r - 4'h1;
               end
            end
            MS_GUARD: begin
               // Ignore stale ready until the own edge has pulled the line low
               if (start_fall) begin
                  guard_cnt_r <= CNT_W'(SYNC_GUARD_CYC);
               end else if (guard_cnt_r != '0) begin
                  guard_cnt_r <= guard_cnt_r - 4'h1;
               end else begin
                  mstate_r <= pend_r ? MS_WAIT_READY : MS_IDLE;
               end
            end
         endcase
      end
   end

   // Start pulse still inside its low cycles
   assign hold_low = (mstate_r == MS_DRIVE_LOW) && (low_cnt_r != '0);

   // Cycle-start pin: master drives high, low during the start pulse; slaves listen
   always_ff @(posedge clk) begin
      if (rst) begin
         start_line <= '{out: 1'b1, oe: 1'b0};
      end else begin
         start_line.oe <= master_on;
         start_line.out <= !start_go && !hold_low;
      end
   end

   // Both timers idle means no cycle runs on this device
   assign timers_idle = (timer_busy == 2'b00);

   // Local conditions: enabled, local logic ready, no timer running, no start edge in this cycle
   assign local_go = enabled && local_ready && timers_idle && !start_fall;

   // Ready pin: open drain, only ever pulled low
   always_ff @(posedge clk) begin
      if (rst) begin
         ready_line <= '{out: 1'b0, oe: 1'b0};
      end else begin
         ready_line.out <= 1'b0;
         ready_line.oe <= area_scan && !local_go;
      end
   end

   // Both timers start from the same shared edge with their own settings
   assign timer_cfg[0] = cam_cfg_r;
   assign timer_cfg[1] = stb_cfg_r;
   generate
      for (genvar i = 0; i < 2; i++) begin : g_timer
         assign timer_start[i] = start_fall;
         mcts_pulse_timer u_timer (
            .clk(clk),
            .rst(rst),
            .start(timer_start[i]),
            .cfg(timer_cfg[i]),
            .pulse(timer_pulse[i]),
            .busy(timer_busy[i])
         );
      end
   endgenerate

   // Output flop for the camera trigger
   always_ff @(posedge clk) begin
      if (rst) begin
         camera_trigger <= 1'b0;
      end else begin
         camera_trigger <= timer_pulse[0];
      end
   end

   // Output flop for the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         strobe <= 1'b0;
      end else begin
         strobe <= timer_pulse[1];
      end
   end

   // Output flop for cycle activity
   always_ff @(posedge clk) begin
      if (rst) begin
         cycle_active <= 1'b0;
      end else begin
         cycle_active <= !timers_idle;
      end
   end

   // Count of cycles started on this device
   always_ff @(posedge clk) begin
      if (rst) begin
         cycle_count_r <= '0;
      end else if (start_fall) begin
         cycle_count_r <= cycle_count_r + 32'h0000_0001;
      end
   end
endmodule : mcts_cycle_sync
`default_nettype wire

/* File: hdl/mcts_pkg.sv */
// Package: constants, register map and types for the shared cycle trigger block
`default_nettype none
package mcts_pkg;
   // Clock and timing figures
   localparam int CLK_PERIOD_NS = 100;
   localparam int MIN_START_PERIOD_NS = 400;
   localparam int READY_RISE_NS = 100;
   // Least times round up to whole cycles
   localparam int MIN_START_CYC = (MIN_START_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READY_RISE_CYC = (READY_RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Consecutive high samples needed before the ready line counts as settled
   localparam int READY_CONFIRM_CYC = READY_RISE_CYC + 1;
   // Low time of the start pulse, and wait after the own edge before trusting ready
   localparam int START_LOW_CYC = 2;
   localparam int SYNC_GUARD_CYC = 3;
   localparam int CNT_W = 4;

   // Register map, byte addresses
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] ADDR_CAM_DELAY = 5'h04;
   localparam logic [ADDR_W-1:0] ADDR_CAM_WIDTH = 5'h08;
   localparam logic [ADDR_W-1:0] ADDR_STB_DELAY = 5'h0c;
   localparam logic [ADDR_W-1:0] ADDR_STB_WIDTH = 5'h10;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h14;
   localparam logic [ADDR_W-1:0] ADDR_CYCLE_COUNT = 5'h18;

   // Control fields
   localparam int CTRL_MASTER_BIT = 0;
   localparam int CTRL_AREA_BIT = 1;
   localparam int CTRL_EN_BIT = 2;
   localparam int CTRL_SRC_LSB = 4;
   localparam logic [1:0] SRC_CYCLE_TRIGGER = 2'h1;
   localparam logic [6:0] CTRL_RST = 7'h02;
   // Status fields
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int STAT_READY_BIT = 1;
   localparam int STAT_PEND_BIT = 2;
   localparam int STAT_LOCAL_BIT = 3;

   // Pulse timing settings
   localparam int TW = 16;
   localparam logic [TW-1:0] DELAY_RST = 16'h0000;
   localparam logic [TW-1:0] WIDTH_RST = 16'h0001;
   localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

   typedef struct packed {
      logic [TW-1:0] delay;
      logic [TW-1:0] width;
   } mcts_pulse_cfg_t;

   // One pin driver: level driven and enable
   typedef struct packed {
      logic out;
      logic oe;
   } mcts_pin_drv_t;

   typedef enum logic [1:0] {
      MS_IDLE = 2'b00,
      MS_WAIT_READY = 2'b01,
      MS_DRIVE_LOW = 2'b10,
      MS_GUARD = 2'b11
   } mcts_master_state_t;

   typedef enum logic [1:0] {
      TS_IDLE = 2'b00,
      TS_DELAY = 2'b01,
      TS_PULSE = 2'b10
   } mcts_timer_state_t;
endpackage : mcts_pkg
`default_nettype wire

/* File: hdl/mcts_pulse_timer.sv */
// Delay-then-pulse timer started by the common cycle start
`default_nettype none
module mcts_pulse_timer
   import mcts_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire mcts_pulse_cfg_t cfg,
   output logic pulse,
   output logic busy
);
   mcts_timer_state_t state_r;
   logic [TW-1:0] cnt_r;
   logic [TW-1:0] width_r;

   // Delay count, then high for the width count; starts while busy are ignored
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= TS_IDLE;
         cnt_r <= '0;
         width_r <= '0;
         pulse <= 1'b0;
      end else begin
         unique case (state_r)
            TS_IDLE: begin
               if (start) begin
                  cnt_r <= cfg.delay;
                  width_r <= cfg.width;
                  state_r <= TS_DELAY;
               end
            end
            TS_DELAY: begin
               if (cnt_r == '0) begin
                  if (width_r == '0) begin
                     state_r <= TS_IDLE;
                  end else begin
                     cnt_r <= width_r - 16'h0001;
                     pulse <= 1'b1;
                     state_r <= TS_PULSE;
                  end
               end else begin
                  cnt_r <= cnt_r - 16'h0001;
               end
            end
            TS_PULSE: begin
               if (cnt_r == '0) begin
                  pulse <= 1'b0;
                  state_r <= TS_IDLE;
               end else begin
                  cnt_r <= cnt_r - 16'h0001;
               end
            end
            default: begin
               pulse <= 1'b0;
               state_r <= TS_IDLE;
            end
         endcase
      end
   end

   // Busy from the cycle after the start request onward
   assign busy = (state_r != TS_IDLE);
endmodule : mcts_pulse_timer
`default_nettype wire

/* File: verification/mcts_cycle_sync_checker.sv */
// Assertion checker watching the ports of the shared cycle trigger block
`default_nettype none
module mcts_cycle_sync_checker
   import mcts_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic local_ready,
   input wire logic ready_line_in,
   input wire mcts_pin_drv_t ready_line,
   input wire logic start_line_in,
   input wire mcts_pin_drv_t start_line,
   input wire logic camera_trigger,
   input wire logic cycle_active
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Start pulse shape: low one more cycle, then back high
   sequence s_start_low;
      !start_line.out ##1 start_line.out;
   endsequence
   // No further fall within the minimum start period
   sequence s_no_fall;
      !$fell(start_line.out) [*3];
   endsequence
   a_pin_pull_only: assert property (!ready_line.out)
      else $error("ready line driven high");
   a_local_hold: assert property (!local_ready && ready_line.oe |=> ready_line.oe)
      else $error("ready line released while not locally ready");
   // Two synchroniser flops and two confirming samples lie behind the decision
   a_fall_needs_ready: assert property ($fell(start_line.out) |->
      $past(ready_line_in, 4) && $past(ready_line_in, 5))
      else $error("start issued without settled ready");
   a_start_pulse_shape: assert property ($fell(start_line.out) |=> s_start_low)
      else $error("start pulse width wrong");
   a_start_spacing: assert property ($fell(start_line.out) |=> s_no_fall)
      else $error("start edges too close");
   a_cycle_begins: assert property ($fell(start_line_in) && !cycle_active |->
      ##[2:7] cycle_active)
      else $error("start edge did not begin a cycle");
   a_cam_in_cycle: assert property ($rose(camera_trigger) |-> $past(cycle_active))
      else $error("camera trigger outside a cycle");
   a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside its cycle");
   c_start: cover property ($fell(start_line.out));
endmodule : mcts_cycle_sync_checker
`default_nettype wire

/* File: verification/mcts_far_device.sv */
// Behavioural far-side device sharing the ready and cycle-start lines
`default_nettype none
module mcts_far_device (
   input wire logic clk,
   input wire logic rst,
   input wire logic start_wire,
   input wire logic [7:0] busy_len,
   output logic ready_pull
);
   timeunit 1ns;
   timeprecision 1ns;
   logic start_d_r;
   logic [7:0] busy_r;
   // Detect the start fall and stay busy for the chosen span
   always_ff @(posedge clk) begin
      if (rst) begin
         start_d_r <= 1'b1;
         busy_r <= 8'h00;
      end else begin
         start_d_r <= start_wire;
         if (start_d_r && !start_wire) begin
            busy_r <= busy_len;
         end else if (busy_r != 8'h00) begin
            busy_r <= busy_r - 8'h01;
         end
      end
   end
   // Pull the wired-AND ready line low while not able to start
   assign ready_pull = rst || (busy_r != 8'h00);
endmodule : mcts_far_device
`default_nettype wire

/* File: verification/tb_top.sv */
// Testbench: master device and one far-side device on the shared lines
`default_nettype none
module tb_top import mcts_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] reg_addr = 5'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic trig_in = 1'b0;
   logic local_ready = 1'b1;
   logic [7:0] busy_len = 8'h1e;
   logic [31:0] reg_rdata;
   logic far_pull, ready_wire, start_wire, camera_trigger, strobe, cycle_active;
   logic start_q = 1'b1;
   mcts_pin_drv_t ready_line, start_line;
   int falls = 0, since = 0, cam_at = 0, stb_at = 0, cam_w = 0, stb_w = 0, n = 0;
   int fail_count = 0, n_checks = 0;
   // Wired-AND ready with pull-up; start line pulled up when released
   assign ready_wire = !(ready_line.oe && !ready_line.out) && !far_pull;
   assign start_wire = start_line.oe ? start_line.out : 1'b1;
   mcts_cycle_sync mcts_cycle_sync_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cycle_trigger_in(trig_in), .local_ready(local_ready), .ready_line_in(ready_wire),
      .ready_line(ready_line), .start_line_in(start_wire), .start_line(start_line),
      .camera_trigger(camera_trigger), .strobe(strobe), .cycle_active(cycle_active));
   mcts_far_device mcts_far_device_inst (.clk(clk), .rst(rst), .start_wire(start_wire),
      .busy_len(busy_len), .ready_pull(far_pull));
   initial begin
      forever #50 clk = ~clk;
   end
   // Count start falls and time the pulses after each one
   always @(posedge clk) begin
      start_q <= start_wire;
      since <= since + 1;
      if (camera_trigger) cam_w <= cam_w + 1;
      if (strobe) stb_w <= stb_w + 1;
      if (camera_trigger && cam_w == 0) cam_at <= since;
      if (strobe && stb_w == 0) stb_at <= since;
      if (start_q && !start_wire) begin
         falls <= falls + 1;
         since <= 0;
         cam_w <= 0;
         stb_w <= 0;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask : rd_chk
   task automatic trig();
      @(posedge clk);
      trig_in <= 1'b1;
      @(posedge clk);
      trig_in <= 1'b0;
   endtask : trig
   // Wait a bounded number of cycles for the next start fall
   task automatic wait_fall(input int lim, output int cnt);
      int f0;
      f0 = falls;
      cnt = 0;
      while (falls == f0 && cnt < lim) begin
         @(posedge clk);
         #1;
         cnt++;
      end
   endtask : wait_fall
   task automatic give_verdict();
      $display("Checks %0d, errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      give_verdict();
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd_chk(ADDR_CTRL, {25'h0, CTRL_RST});
      rd_chk(ADDR_CAM_DELAY, 32'h0);
      rd_chk(ADDR_STB_WIDTH, 32'h1);
      rd_chk(5'h1c, RDATA_UNMAPPED);
      wr(ADDR_CYCLE_COUNT, 32'h5);
      rd_chk(ADDR_CYCLE_COUNT, 32'h0);
      wr(ADDR_CTRL, 32'h57);
      rd_chk(ADDR_CTRL, 32'h57);
      wr(ADDR_CAM_DELAY, 32'h3);
      wr(ADDR_CAM_WIDTH, 32'h4);
      wr(ADDR_STB_DELAY, 32'h1);
      wr(ADDR_STB_WIDTH, 32'h2);
      // Master role, area-scan, enabled, cycle trigger as the start source
      wr(ADDR_CTRL, 32'h17);
      // Master start with ready settled, then own ready held low and own camera and strobe pulses
      repeat (10) @(posedge clk);
      trig();
      wait_fall(20, n);
      chk({31'h0, n < 20}, 32'h1);
      repeat (6) @(posedge clk);
      #1;
      chk({31'h0, ready_line.oe}, 32'h1);
      repeat (30) @(posedge clk);
      #1;
      chk(cam_w, 32'h4);
      chk(stb_w, 32'h2);
      chk(cam_at - stb_at, 32'h2);
      // Local not ready holds the start back; two triggers merge into one
      local_ready <= 1'b0;
      repeat (6) @(posedge clk);
      trig();
      trig();
      repeat (20) @(posedge clk);
      rd_chk(ADDR_CYCLE_COUNT, 32'h1);
      // Far side takes the long busy span at this start
      busy_len <= 8'h3c;
      local_ready <= 1'b1;
      wait_fall(20, n);
      chk({31'h0, n < 20}, 32'h1);
      repeat (10) @(posedge clk);
      rd_chk(ADDR_CYCLE_COUNT, 32'h2);
      // Slow far side keeps the ready line low after the start
      trig();
      wait_fall(100, n);
      chk({31'h0, n > 40 && n < 100}, 32'h1);
      busy_len <= 8'h00;
      repeat (70) @(posedge clk);
      // Line-scan: no ready mechanism at all
      wr(ADDR_CTRL, 32'h15);
      local_ready <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk({31'h0, ready_line.oe}, 32'h0);
      trig();
      wait_fall(20, n);
      chk({31'h0, n < 20}, 32'h1);
      repeat (20) @(posedge clk);
      // Slave role: start pin released and triggers ignored
      wr(ADDR_CTRL, 32'h16);
      trig();
      wait_fall(20, n);
      chk({31'h0, start_line.oe}, 32'h0);
      chk({31'h0, n == 20}, 32'h1);
      give_verdict();
   end
endmodule : tb_top
bind mcts_cycle_sync mcts_cycle_sync_checker mcts_cycle_sync_checker_inst (.clk(clk),
   .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .local_ready(local_ready),
   .ready_line_in(ready_line_in), .ready_line(ready_line), .start_line_in(start_line_in),
   .start_line(start_line), .camera_trigger(camera_trigger), .cycle_active(cycle_active));
`default_nettype wire
